// *** ecsl_regs.svh ***
/*
  Constants of the engine command/status link: line levels, frame layout,
  bit timing and the initialise command code.
  Assumes a 100 MHz core clock; included by bare name.
*/
`ifndef ECSL_REGS_SVH
`define ECSL_REGS_SVH

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define ECSL_CLK_HZ 100000000
`define ECSL_BAUD_BPS 9600
`define ECSL_BIT_CYCLES (`ECSL_CLK_HZ / `ECSL_BAUD_BPS)

// -----------------------------------------------------------------
// Frame layout, levels, init command, key count and buffer depth
// -----------------------------------------------------------------
`define ECSL_DATA_BITS 8
`define ECSL_LINE_MARK 1'b1
`define ECSL_LINE_SPACE 1'b0
`define ECSL_INIT_CMD 8'h01
`define ECSL_KEYS 8
`define ECSL_BUF_DEPTH 2

`endif

// *** ecsl_pkg.sv ***
/*
  Types shared by the engine command/status link modules.
  Assumes ecsl_regs.svh sits in the same folder.
*/
`include "ecsl_regs.svh"

package ecsl_pkg;

  // -----------------------------------------------------------------
  // Frame sequencer states, Gray coded along the frame
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_IDLE   = 3'h0,
    FR_START  = 3'h1,
    FR_DATA   = 3'h3,
    FR_PARITY = 3'h2,
    FR_STOP   = 3'h6
  } ecsl_frame_state_t;

  // Received command byte with its checks
  typedef struct packed {
    logic [`ECSL_DATA_BITS-1:0] data;
    logic parity_err;
    logic stop_err;
  } ecsl_rx_word_t;

endpackage

// *** ecsl_buf.sv ***
/*
  Two-entry valid/ready buffer for status bytes waiting to go out.
  Assumes one clock, an active-high asynchronous reset and a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ecsl_regs.svh"

module ecsl_buf #(
  parameter int WIDTH = `ECSL_DATA_BITS,
  parameter int DEPTH = `ECSL_BUF_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic push, pop;

  // -----------------------------------------------------------------
  // Pointer and fill count
  // -----------------------------------------------------------------
  always_comb begin
    push = in_valid_in && ready_reg;
    pop = out_ready_in && (count_reg != '0);
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    ready_next = (count_next != CW'(DEPTH));
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else if (ce_in) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge core_clk_in) begin
    if (ce_in && push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  assign in_ready_out = ready_reg;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];

endmodule
`default_nettype wire

// *** ecsl_link.sv ***
/*
  Engine end of the command/status serial link with its handshake lines.
  Assumes all inputs are synchronous to core_clk_in (100 MHz), lines idle
  high, and the engine logic supplies status bytes to answer commands.
*/
// How it works
// - Bytes go asynchronously, commands in, status out, never both at once; the code only holds status until the receiver idles at mid stop bit.
// - Every bit on both lines lasts one 9600 bps bit time.
// - A frame opens with one start bit and then eight data bits.
// - Data bits travel least significant first, right after the start bit.
// - One parity bit follows the data so the count of ones is odd.
// - Each command is answered by one status byte before the next exchange; the code owes answers only for delivered commands and never holds off the next.
// - The engine drives its ready line to show it is ready for operation.
// - The engine flags key-change when a panel key switch changes.
`timescale 1ns/1ps
`default_nettype none
`include "ecsl_regs.svh"

module ecsl_link #(
  parameter int BIT_CYCLES = `ECSL_BIT_CYCLES,
  parameter int KEYS = `ECSL_KEYS
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic command_line_in,
  output logic status_line_out,
  input wire logic print_request_line_n_in,
  output logic print_request_out,
  input wire logic engine_ready_in,
  output logic engine_ready_line_n_out,
  input wire logic [KEYS-1:0] key_status_in,
  input wire logic key_query_in,
  output logic key_change_n_out,
  input wire logic stat_valid_in,
  input wire logic [`ECSL_DATA_BITS-1:0] stat_data_in,
  output logic stat_ready_out,
  output logic cmd_valid_out,
  output ecsl_pkg::ecsl_rx_word_t cmd_word_out,
  output logic link_up_out
);
  localparam int DW = `ECSL_DATA_BITS;
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam int IW = $clog2(DW);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
  localparam logic [IW-1:0] IDX_LAST = IW'(DW - 1);

  ecsl_pkg::ecsl_frame_state_t rx_state_reg, rx_state_next;
  ecsl_pkg::ecsl_frame_state_t tx_state_reg, tx_state_next;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [IW-1:0] rx_idx_reg, rx_idx_next, tx_idx_reg, tx_idx_next;
  logic [DW-1:0] rx_shift_reg, rx_shift_next, tx_byte_reg, tx_byte_next;
  logic rx_pbit_reg, rx_pbit_next, rx_done;
  logic tx_line_reg, tx_line_next, tx_finish, buf_take;
  logic buf_valid;
  logic [DW-1:0] buf_data;
  logic cmd_valid_reg, cmd_valid_next, link_up_reg, link_up_next;
  logic answer_owed_reg, answer_owed_next, rx_perr, is_init;
  ecsl_pkg::ecsl_rx_word_t cmd_word_reg, cmd_word_next;
  logic [KEYS-1:0] key_prev_reg, key_prev_next;
  logic key_armed_reg, key_chg_n_reg, key_chg_n_next;
  logic ready_n_reg, ready_n_next, print_req_reg, print_req_next;

  // -----------------------------------------------------------------
  // Status byte buffer
  // -----------------------------------------------------------------
  ecsl_buf #(.WIDTH(DW), .DEPTH(`ECSL_BUF_DEPTH)) u_stat_buf (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .in_valid_in(stat_valid_in),
    .in_data_in(stat_data_in),
    .in_ready_out(stat_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(buf_take)
  );

  // -----------------------------------------------------------------
  // Command receiver
  // -----------------------------------------------------------------
  // Counts from the start edge so later samples fall mid-bit
  always_comb begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg + 1'b1;
    rx_idx_next = rx_idx_reg;
    rx_shift_next = rx_shift_reg;
    rx_pbit_next = rx_pbit_reg;
    rx_done = 1'b0;
    unique case (rx_state_reg)
      ecsl_pkg::FR_IDLE: begin
        rx_cnt_next = '0;
        if (command_line_in != `ECSL_LINE_MARK) begin
          rx_state_next = ecsl_pkg::FR_START;
        end
      end
      ecsl_pkg::FR_START: begin
        if (rx_cnt_reg == HALF_LAST) begin
          rx_cnt_next = '0;
          rx_idx_next = '0;
          rx_state_next = (command_line_in == `ECSL_LINE_SPACE) ?
              ecsl_pkg::FR_DATA : ecsl_pkg::FR_IDLE;
        end
      end
      ecsl_pkg::FR_DATA: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_cnt_next = '0;
          rx_shift_next = {command_line_in, rx_shift_reg[DW-1:1]};
          rx_idx_next = rx_idx_reg + 1'b1;
          if (rx_idx_reg == IDX_LAST) begin
            rx_state_next = ecsl_pkg::FR_PARITY;
          end
        end
      end
      ecsl_pkg::FR_PARITY: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_cnt_next = '0;
          rx_pbit_next = command_line_in;
          rx_state_next = ecsl_pkg::FR_STOP;
        end
      end
      ecsl_pkg::FR_STOP: begin
        if (rx_cnt_reg == BIT_LAST) begin
          rx_done = 1'b1;
          rx_state_next = ecsl_pkg::FR_IDLE;
        end
      end
      default: rx_state_next = ecsl_pkg::FR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state_reg <= ecsl_pkg::FR_IDLE;
      rx_cnt_reg <= '0;
      rx_idx_reg <= '0;
      rx_shift_reg <= '0;
      rx_pbit_reg <= 1'b0;
    end else if (ce_in) begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_idx_reg <= rx_idx_next;
      rx_shift_reg <= rx_shift_next;
      rx_pbit_reg <= rx_pbit_next;
    end
  end

  // -----------------------------------------------------------------
  // Command delivery, link establishment and answer tracking
  // -----------------------------------------------------------------
  always_comb begin
    rx_perr = ~(^{rx_shift_reg, rx_pbit_reg});
    is_init = (rx_shift_reg == `ECSL_INIT_CMD);
    cmd_valid_next = rx_done && (link_up_reg || is_init);
    cmd_word_next = cmd_word_reg;
    if (rx_done) begin
      cmd_word_next.data = rx_shift_reg;
      cmd_word_next.parity_err = rx_perr;
      cmd_word_next.stop_err = (command_line_in != `ECSL_LINE_MARK);
    end
    link_up_next = link_up_reg ||
        (rx_done && is_init && !rx_perr &&
         command_line_in == `ECSL_LINE_MARK);
    // A new command outranks the end of the previous answer
    answer_owed_next = cmd_valid_next ? 1'b1 :
        (tx_finish ? 1'b0 : answer_owed_reg);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_valid_reg <= 1'b0;
      cmd_word_reg <= '0;
      link_up_reg <= 1'b0;
      answer_owed_reg <= 1'b0;
    end else if (ce_in) begin
      cmd_valid_reg <= cmd_valid_next;
      cmd_word_reg <= cmd_word_next;
      link_up_reg <= link_up_next;
      answer_owed_reg <= answer_owed_next;
    end
  end

  // -----------------------------------------------------------------
  // Status transmitter
  // -----------------------------------------------------------------
  // Starts only with an answer owed and the command line quiet
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg + 1'b1;
    tx_idx_next = tx_idx_reg;
    tx_byte_next = tx_byte_reg;
    tx_line_next = tx_line_reg;
    tx_finish = 1'b0;
    buf_take = 1'b0;
    unique case (tx_state_reg)
      ecsl_pkg::FR_IDLE: begin
        tx_cnt_next = '0;
        tx_line_next = `ECSL_LINE_MARK;
        if (buf_valid && answer_owed_reg &&
            rx_state_reg == ecsl_pkg::FR_IDLE) begin
          buf_take = ce_in;
          tx_byte_next = buf_data;
          tx_line_next = `ECSL_LINE_SPACE;
          tx_state_next = ecsl_pkg::FR_START;
        end
      end
      ecsl_pkg::FR_START: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_cnt_next = '0;
          tx_idx_next = '0;
          tx_line_next = tx_byte_reg[0];
          tx_state_next = ecsl_pkg::FR_DATA;
        end
      end
      ecsl_pkg::FR_DATA: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_cnt_next = '0;
          tx_idx_next = tx_idx_reg + 1'b1;
          if (tx_idx_reg == IDX_LAST) begin
            tx_line_next = ~(^tx_byte_reg);
            tx_state_next = ecsl_pkg::FR_PARITY;
          end else begin
            tx_line_next = tx_byte_reg[tx_idx_reg + 1'b1];
          end
        end
      end
      ecsl_pkg::FR_PARITY: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_cnt_next = '0;
          tx_line_next = `ECSL_LINE_MARK;
          tx_state_next = ecsl_pkg::FR_STOP;
        end
      end
      ecsl_pkg::FR_STOP: begin
        if (tx_cnt_reg == BIT_LAST) begin
          tx_finish = 1'b1;
          tx_state_next = ecsl_pkg::FR_IDLE;
        end
      end
      default: begin
        tx_line_next = `ECSL_LINE_MARK;
        tx_state_next = ecsl_pkg::FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_state_reg <= ecsl_pkg::FR_IDLE;
      tx_cnt_reg <= '0;
      tx_idx_reg <= '0;
      tx_byte_reg <= '0;
      tx_line_reg <= `ECSL_LINE_MARK;
    end else if (ce_in) begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_idx_reg <= tx_idx_next;
      tx_byte_reg <= tx_byte_next;
      tx_line_reg <= tx_line_next;
    end
  end

  // -----------------------------------------------------------------
  // Handshake lines: ready, print request, key change
  // -----------------------------------------------------------------
  always_comb begin
    ready_n_next = !(engine_ready_in && link_up_reg);
    print_req_next = !print_request_line_n_in;
    key_prev_next = key_status_in;
    // A key change in the query cycle keeps the flag set
    key_chg_n_next = !((key_armed_reg && key_status_in != key_prev_reg) ||
        (!key_chg_n_reg && !key_query_in));
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_n_reg <= 1'b1;
      print_req_reg <= 1'b0;
      key_prev_reg <= '0;
      key_armed_reg <= 1'b0;
      key_chg_n_reg <= 1'b1;
    end else if (ce_in) begin
      ready_n_reg <= ready_n_next;
      print_req_reg <= print_req_next;
      key_prev_reg <= key_prev_next;
      key_armed_reg <= 1'b1;
      key_chg_n_reg <= key_chg_n_next;
    end
  end

  assign status_line_out = tx_line_reg;
  assign engine_ready_line_n_out = ready_n_reg;
  assign print_request_out = print_req_reg;
  assign key_change_n_out = key_chg_n_reg;
  assign cmd_valid_out = cmd_valid_reg;
  assign cmd_word_out = cmd_word_reg;
  assign link_up_out = link_up_reg;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_tx_half_duplex;
    @(posedge core_clk_in) disable iff (rst_in)
    (tx_state_reg == ecsl_pkg::FR_IDLE &&
     tx_state_next == ecsl_pkg::FR_START)
    |-> (rx_state_reg == ecsl_pkg::FR_IDLE && answer_owed_reg);
  endproperty
  a_tx_half_duplex: assert property (p_tx_half_duplex)
    else $error("status frame started while command line busy");

  property p_tx_bit_time;
    @(posedge core_clk_in) disable iff (rst_in)
    (tx_state_reg != ecsl_pkg::FR_IDLE && tx_state_next != tx_state_reg)
    |-> tx_cnt_reg == BIT_LAST;
  endproperty
  a_tx_bit_time: assert property (p_tx_bit_time)
    else $error("status bit ended before a full bit time");

  property p_tx_start_low;
    @(posedge core_clk_in) disable iff (rst_in)
    tx_state_reg == ecsl_pkg::FR_START |-> !status_line_out;
  endproperty
  a_tx_start_low: assert property (p_tx_start_low)
    else $error("start bit not at space level");

  property p_tx_lsb_first;
    @(posedge core_clk_in) disable iff (rst_in)
    tx_state_reg == ecsl_pkg::FR_DATA
    |-> status_line_out == tx_byte_reg[tx_idx_reg];
  endproperty
  a_tx_lsb_first: assert property (p_tx_lsb_first)
    else $error("data bit out of order");

  property p_tx_odd_parity;
    @(posedge core_clk_in) disable iff (rst_in)
    tx_state_reg == ecsl_pkg::FR_PARITY
    |-> (^{tx_byte_reg, status_line_out}) == 1'b1;
  endproperty
  a_tx_odd_parity: assert property (p_tx_odd_parity)
    else $error("parity bit does not make ones odd");

  property p_tx_mark;
    @(posedge core_clk_in) disable iff (rst_in)
    (tx_state_reg == ecsl_pkg::FR_STOP ||
     tx_state_reg == ecsl_pkg::FR_IDLE) |-> status_line_out;
  endproperty
  a_tx_mark: assert property (p_tx_mark)
    else $error("line not at mark in stop or idle");

  property p_answer_done;
    @(posedge core_clk_in) disable iff (rst_in)
    (ce_in && tx_finish && !rx_done) |=> !answer_owed_reg;
  endproperty
  a_answer_done: assert property (p_answer_done)
    else $error("answer still owed after status frame");

  property p_ready_line;
    @(posedge core_clk_in) disable iff (rst_in)
    ce_in |=> engine_ready_line_n_out ==
        !($past(engine_ready_in) && $past(link_up_reg));
  endproperty
  a_ready_line: assert property (p_ready_line)
    else $error("ready line does not follow engine state");

  property p_key_change;
    @(posedge core_clk_in) disable iff (rst_in)
    (ce_in && key_armed_reg && key_status_in != key_prev_reg)
    |=> !key_change_n_out;
  endproperty
  a_key_change: assert property (p_key_change)
    else $error("key change not flagged");

  property p_rx_mid_sample;
    @(posedge core_clk_in) disable iff (rst_in)
    (rx_state_reg == ecsl_pkg::FR_START &&
     rx_state_next == ecsl_pkg::FR_DATA) |-> rx_cnt_reg == HALF_LAST;
  endproperty
  a_rx_mid_sample: assert property (p_rx_mid_sample)
    else $error("start bit not checked at mid-bit");

endmodule
`default_nettype wire

// *** ecsl_ctrl_model.sv ***
/*
  Controller-side model of the command/status link: sends command frames
  and decodes the engine's status frames.
  Assumes the core clock of the engine and lines that idle high.
*/
`timescale 1ns/1ps
`default_nettype none

module ecsl_ctrl_model #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic core_clk_in,
  output logic command_line_out,
  input wire logic status_line_in
);
  logic [7:0] rx_byte;
  logic rx_frame_ok;
  logic rx_par;
  logic rx_start_ok;
  logic sending = 1'b0;
  int rx_count = 0;
  int overlap_count = 0;

  // Idle at mark between frames
  initial command_line_out = 1'b1;

  // ---------------------------------------------------------------
  // Command transmitter
  // ---------------------------------------------------------------
  // One frame per call; a bad stop lasts half a bit plus one clock, low at the stop
  // sample yet back at mark before the receiver rearms
  task automatic send_byte(input logic [7:0] d, input logic bad_par,
                           input logic bad_stop);
    logic [10:0] frame;
    frame = {~bad_stop, (~^d) ^ bad_par, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge core_clk_in);
      #1 command_line_out = frame[i];
      if (i == 10) begin
        sending = 1'b0;
      end
      if (i == 10 && bad_stop) begin
        repeat (BIT_CYCLES / 2) @(posedge core_clk_in);
      end else begin
        repeat (BIT_CYCLES - 1) @(posedge core_clk_in);
      end
    end
    @(posedge core_clk_in);
    #1 command_line_out = 1'b1;
  endtask

  // Status line stays idle while start, data or parity bits of a
  // command are on the wire; the stop bit already sits at mark
  always @(posedge core_clk_in) begin
    if (sending && status_line_in !== 1'b1) begin
      overlap_count++;
    end
  end

  // ---------------------------------------------------------------
  // Status receiver
  // ---------------------------------------------------------------
  // Samples each bit near its middle and checks parity and stop
  always begin
    @(posedge core_clk_in);
    if (status_line_in === 1'b0) begin
      repeat (BIT_CYCLES / 2) @(posedge core_clk_in);
      rx_start_ok = (status_line_in === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge core_clk_in);
        rx_byte[i] = status_line_in;
      end
      repeat (BIT_CYCLES) @(posedge core_clk_in);
      rx_par = status_line_in;
      repeat (BIT_CYCLES) @(posedge core_clk_in);
      rx_frame_ok = rx_start_ok && ((^rx_byte ^ rx_par) === 1'b1) &&
                    (status_line_in === 1'b1);
      rx_count++;
    end
  end
endmodule
`default_nettype wire

// *** ecsl_link_tb.sv ***
/*
  Self-checking bench for the engine end of the command/status link.
  Assumes ecsl_pkg and the controller model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module ecsl_link_tb;
  localparam int BIT = 8;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic command_line;
  logic print_request_line_n_in = 1'b1;
  logic engine_ready_in = 1'b1;
  logic key_query_in = 1'b0;
  logic stat_valid_in = 1'b0;
  logic [7:0] key_status_in = 8'h00;
  logic [7:0] stat_data_in = 8'h00;
  logic status_line_out;
  logic print_request_out;
  logic engine_ready_line_n_out;
  logic key_change_n_out;
  logic stat_ready_out;
  logic cmd_valid_out;
  logic link_up_out;
  ecsl_pkg::ecsl_rx_word_t cmd_word_out;
  ecsl_pkg::ecsl_rx_word_t last_cmd;
  int bad_count = 0;
  int compares = 0;
  int cmd_count = 0;

  // ---------------------------------------------------------------
  // Clock, design and controller model
  // ---------------------------------------------------------------
  always #5 core_clk_in = ~core_clk_in;

  ecsl_link #(.BIT_CYCLES(BIT), .KEYS(8)) u_ecsl_link (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .command_line_in(command_line), .status_line_out(status_line_out),
    .print_request_line_n_in(print_request_line_n_in),
    .print_request_out(print_request_out),
    .engine_ready_in(engine_ready_in),
    .engine_ready_line_n_out(engine_ready_line_n_out),
    .key_status_in(key_status_in), .key_query_in(key_query_in),
    .key_change_n_out(key_change_n_out), .stat_valid_in(stat_valid_in),
    .stat_data_in(stat_data_in), .stat_ready_out(stat_ready_out),
    .cmd_valid_out(cmd_valid_out), .cmd_word_out(cmd_word_out),
    .link_up_out(link_up_out));

  ecsl_ctrl_model #(.BIT_CYCLES(BIT)) u_ecsl_ctrl_model (
    .core_clk_in(core_clk_in), .command_line_out(command_line),
    .status_line_in(status_line_out));

  // Catches every delivered command word
  always @(posedge core_clk_in) begin
    if (cmd_valid_out === 1'b1) begin
      cmd_count++;
      last_cmd = cmd_word_out;
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bounded wait for a counter to move past a start value
  task automatic wait_count(input string what, ref int cnt, input int from);
    int n;
    n = 0;
    while (cnt == from && n < 20 * BIT) begin
      @(posedge core_clk_in);
      #2 n++;
    end
    if (cnt == from) begin
      bad_count++;
      $display("BAD %s expected event seen timeout", what);
      final_report();
    end
  endtask

  // Offers one status byte and holds it until taken
  task automatic push(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk_in);
    #1 stat_valid_in = 1'b1;
    stat_data_in = d;
    while (stat_ready_out !== 1'b1 && n < 20 * BIT) begin
      @(posedge core_clk_in);
      #1 n++;
    end
    if (stat_ready_out !== 1'b1) begin
      bad_count++;
      $display("BAD push expected ready seen timeout");
      final_report();
    end
    @(posedge core_clk_in);
    #1 stat_valid_in = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check("status_line", 10'h001, status_line_out);
    check("ready_pin_n", 10'h001, engine_ready_line_n_out);
    check("link_up", 10'h000, link_up_out);
  endtask

  task automatic t_before_init();
    int c;
    c = cmd_count;
    u_ecsl_ctrl_model.send_byte(8'h55, 1'b0, 1'b0);
    check("refused_count", 10'(c), 10'(cmd_count));
    u_ecsl_ctrl_model.send_byte(8'h01, 1'b1, 1'b0);
    wait_count("bad_init", cmd_count, c);
    check("bad_init_word", {8'h01, 2'b10}, last_cmd);
    check("link_up", 10'h000, link_up_out);
  endtask

  task automatic t_init_answer();
    int c;
    int r;
    c = cmd_count;
    r = u_ecsl_ctrl_model.rx_count;
    // Answer owed from the flagged init; byte offered mid-command
    fork
      u_ecsl_ctrl_model.send_byte(8'h01, 1'b0, 1'b0);
      begin
        repeat (3 * BIT) @(posedge core_clk_in);
        push(8'hA5);
      end
    join
    wait_count("init", cmd_count, c);
    check("init_word", {8'h01, 2'b00}, last_cmd);
    check("link_up", 10'h001, link_up_out);
    repeat (2) @(posedge core_clk_in);
    check("ready_pin_n", 10'h000, engine_ready_line_n_out);
    wait_count("answer", u_ecsl_ctrl_model.rx_count, r);
    check("status_byte", 10'h0A5, u_ecsl_ctrl_model.rx_byte);
    check("status_ok", 10'h001, u_ecsl_ctrl_model.rx_frame_ok);
  endtask

  task automatic t_bad_stop();
    int c;
    int r;
    c = cmd_count;
    r = u_ecsl_ctrl_model.rx_count;
    u_ecsl_ctrl_model.send_byte(8'h3C, 1'b0, 1'b1);
    wait_count("bad_stop", cmd_count, c);
    check("bad_stop_word", {8'h3C, 2'b01}, last_cmd);
    push(8'h5A);
    wait_count("answer", u_ecsl_ctrl_model.rx_count, r);
    check("status_byte", 10'h05A, u_ecsl_ctrl_model.rx_byte);
  endtask

  // Fills the buffer with no answer owed, then drains one per command
  task automatic t_buffer();
    int r;
    push(8'h11);
    push(8'h22);
    repeat (2) @(posedge core_clk_in);
    #1 check("stat_ready_full", 10'h000, stat_ready_out);
    check("status_idle", 10'h001, status_line_out);
    for (int i = 0; i < 2; i++) begin
      r = u_ecsl_ctrl_model.rx_count;
      u_ecsl_ctrl_model.send_byte(8'h40 + 8'(i), 1'b0, 1'b0);
      wait_count("drain", u_ecsl_ctrl_model.rx_count, r);
      check("drain_byte", 10'(8'h11 * (i + 1)),
            u_ecsl_ctrl_model.rx_byte);
      repeat (14 * BIT) @(posedge core_clk_in);
      check("one_answer", 10'(r + 1),
            10'(u_ecsl_ctrl_model.rx_count));
    end
    check("overlap", 10'h000,
          10'(u_ecsl_ctrl_model.overlap_count));
  endtask

  task automatic t_lines();
    #1 print_request_line_n_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 check("print_req", 10'h001, print_request_out);
    print_request_line_n_in = 1'b1;
    key_status_in = 8'h04;
    repeat (8) @(posedge core_clk_in);
    #1 check("key_change_n", 10'h000, key_change_n_out);
    key_query_in = 1'b1;
    @(posedge core_clk_in);
    #1 key_query_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 check("key_cleared_n", 10'h001, key_change_n_out);
    engine_ready_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 check("ready_pin_n", 10'h001, engine_ready_line_n_out);
    // Clock enable low freezes the print request register
    ce_in = 1'b0;
    print_request_line_n_in = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 check("print_req_frozen", 10'h000, print_request_out);
    ce_in = 1'b1;
    print_request_line_n_in = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk_in);
    #1 rst_in = 1'b0;
    t_reset();
    t_before_init();
    t_init_answer();
    t_bad_stop();
    t_buffer();
    t_lines();
    final_report();
  end
endmodule
`default_nettype wire
